// ### common/trcm_defs.svh
/*
 Constants of the touch region command mapper: grid sizes, timing, defaults.
 Assumes a 125 MHz system clock and a synchronous active-high reset.
*/
`ifndef TRCM_DEFS_SVH
`define TRCM_DEFS_SVH
`define TRCM_NUM_REGIONS   9
`define TRCM_NUM_SOURCES   6
`define TRCM_CODE_W        16
`define TRCM_COORD_W       12
`define TRCM_SRC_W         3
`define TRCM_HEAD_SRC      3'h0
`define TRCM_NAV_SRC       3'h1
`define TRCM_CLK_MHZ       125
`define TRCM_PULSE_MS      300
`define TRCM_PULSE_CYC     (`TRCM_PULSE_MS * 1000 * `TRCM_CLK_MHZ)
`define TRCM_DEF_XMIN      12'h000
`define TRCM_DEF_XMAX      12'hfff
`define TRCM_DEF_YMIN      12'h000
`define TRCM_DEF_YMAX      12'hfff
`define TRCM_ADDR_W        6
`endif

// ### common/trcm_pkg.sv
/*
 Types of the touch region command mapper.
 Assumes trcm_defs.svh is on the include path.
*/
`include "trcm_defs.svh"
package trcm_pkg;
	typedef struct packed {
		logic [`TRCM_COORD_W-1:0] xmin;
		logic [`TRCM_COORD_W-1:0] xmax;
		logic [`TRCM_COORD_W-1:0] ymin;
		logic [`TRCM_COORD_W-1:0] ymax;
		logic                     status_hi;
		logic                     mute_hi;
		logic                     icept_hi;
		logic                     intercept_mode;
		logic                     pulse_mode;
		logic [`TRCM_SRC_W-1:0]   source;
	} trcm_cfg_t;
	typedef struct packed {
		logic                     valid;
		logic [`TRCM_COORD_W-1:0] x;
		logic [`TRCM_COORD_W-1:0] y;
	} trcm_touch_t;
	typedef struct packed {
		logic                     valid;
		logic [3:0]               region;
		logic [`TRCM_CODE_W-1:0]  code;
	} trcm_cmd_t;
	typedef enum logic [1:0] {
		TRCM_IDLE,
		TRCM_LOOK,
		TRCM_SEND
	} trcm_state_t;
endpackage

// ### core/trcm_code_mem.sv
/*
 Code table: nine codes for each of six sources, registered read.
 Assumes the surrounding device keeps its contents through power loss.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trcm_defs.svh"
module trcm_code_mem #(
	parameter int DEPTH = `TRCM_NUM_REGIONS * `TRCM_NUM_SOURCES,
	parameter int WIDTH = `TRCM_CODE_W,
	parameter int AW    = `TRCM_ADDR_W
) (
	// Clock
	input  wire logic             clk,
	// Write port
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	// Read port
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk)
	begin
		if (we && (int'(waddr) < DEPTH))
			mem[waddr] <= wdata;
	end

	always_ff @(posedge clk)
	begin
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// ### core/trcm_top.sv
/*
 Touch region command mapper: classifies touches into nine regions, emits
 the stored code for the selected source, drives side-band lines.
 Assumes inputs synchronous to clk and a tool writing over a plain port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trcm_defs.svh"
module trcm_top #(
	parameter int PULSE_CYC = `TRCM_PULSE_CYC
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// Register port
	input  wire logic [7:0]                reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [31:0]               reg_rdata,
	// Touch panel
	input  wire trcm_pkg::trcm_touch_t     touch,
	input  wire logic                      calib_pt_valid,
	input  wire logic                      calib_pt_second,
	// Control code out
	output trcm_pkg::trcm_cmd_t            cmd,
	// Side-band lines
	input  wire logic                      intercept_control_input,
	input  wire logic                      navigation_unit_speaking,
	input  wire logic                      touch_status_or_ir_learn_line_in,
	output logic                           touch_status_or_ir_learn_line_out,
	output logic                           touch_status_or_ir_learn_line_oe,
	output logic                           mute_or_ir_supply_line,
	output logic                           panel_disconnect,
	output logic                           ir_learn_valid,
	output logic                           source_switch_output,
	output logic      [`TRCM_SRC_W-1:0]    active_source
);
	import trcm_pkg::*;

	localparam logic [7:0] A_XMIN   = 8'h00;
	localparam logic [7:0] A_XMAX   = 8'h04;
	localparam logic [7:0] A_YMIN   = 8'h08;
	localparam logic [7:0] A_YMAX   = 8'h0c;
	localparam logic [7:0] A_MODE   = 8'h10;
	localparam logic [7:0] A_SRC    = 8'h14;
	localparam logic [7:0] A_CMD    = 8'h18;
	localparam logic [7:0] A_STAT   = 8'h1c;
	localparam logic [7:0] A_CODE   = 8'h40;
	localparam logic [7:0] A_CODEHI = 8'h80;

	trcm_cfg_t                shadow_q;
	trcm_cfg_t                live_q;
	logic [`TRCM_COORD_W-1:0] x1_q;
	logic [`TRCM_COORD_W-1:0] x2_q;
	logic [`TRCM_COORD_W-1:0] y1_q;
	logic [`TRCM_COORD_W-1:0] y2_q;
	logic                     learn_q;
	trcm_state_t              st_q;
	logic [3:0]               region_q;
	logic [31:0]              pulse_cnt_q;
	logic [`TRCM_SRC_W-1:0]   prev_src_q;
	logic [`TRCM_COORD_W-1:0] x_base;
	logic [`TRCM_COORD_W-1:0] y_base;
	logic [`TRCM_ADDR_W-1:0]  mem_raddr;
	logic [`TRCM_CODE_W-1:0]  mem_rdata;
	logic                     mem_we;
	logic [`TRCM_ADDR_W-1:0]  mem_waddr;
	logic [`TRCM_COORD_W+1:0] sx;
	logic [`TRCM_COORD_W+1:0] sy;
	logic [1:0]               col;
	logic [1:0]               row;

	trcm_cfg_t def_cfg;
	always_comb
	begin
		def_cfg = '0;
		def_cfg.xmin = `TRCM_DEF_XMIN;
		def_cfg.xmax = `TRCM_DEF_XMAX;
		def_cfg.ymin = `TRCM_DEF_YMIN;
		def_cfg.ymax = `TRCM_DEF_YMAX;
		def_cfg.source = `TRCM_HEAD_SRC;
	end

	// Staged settings; the tool writes here first.
	// Calibration points land here too when no register write shares their cycle, so that a later commit keeps them.
	always_ff @(posedge clk)
	begin
		if (rst)
			shadow_q <= def_cfg;
		else if (reg_wr && reg_addr == A_CMD && reg_wdata[1])
			shadow_q <= def_cfg;
		else if (reg_wr)
		begin
			unique case (reg_addr)
				A_XMIN: shadow_q.xmin <= reg_wdata[`TRCM_COORD_W-1:0];
				A_XMAX: shadow_q.xmax <= reg_wdata[`TRCM_COORD_W-1:0];
				A_YMIN: shadow_q.ymin <= reg_wdata[`TRCM_COORD_W-1:0];
				A_YMAX: shadow_q.ymax <= reg_wdata[`TRCM_COORD_W-1:0];
				A_MODE:
				begin
					shadow_q.status_hi      <= reg_wdata[0];
					shadow_q.mute_hi        <= reg_wdata[1];
					shadow_q.icept_hi       <= reg_wdata[2];
					shadow_q.intercept_mode <= reg_wdata[3];
					shadow_q.pulse_mode     <= reg_wdata[4];
				end
				A_SRC: shadow_q.source <= reg_wdata[`TRCM_SRC_W-1:0];
				default: ;
			endcase
		end
		else if (calib_pt_valid && !calib_pt_second)
		begin
			shadow_q.xmin <= touch.x;
			shadow_q.ymin <= touch.y;
		end
		else if (calib_pt_valid && calib_pt_second)
		begin
			shadow_q.xmax <= touch.x;
			shadow_q.ymax <= touch.y;
		end
	end

	// Live settings change only on commit, default request or calibration.
	always_ff @(posedge clk)
	begin
		if (rst)
			live_q <= def_cfg;
		else if (reg_wr && reg_addr == A_CMD && reg_wdata[1])
			live_q <= def_cfg;
		else if (reg_wr && reg_addr == A_CMD && reg_wdata[0])
			live_q <= shadow_q;
		else if (calib_pt_valid && !calib_pt_second)
		begin
			live_q.xmin <= touch.x;
			live_q.ymin <= touch.y;
		end
		else if (calib_pt_valid && calib_pt_second)
		begin
			live_q.xmax <= touch.x;
			live_q.ymax <= touch.y;
		end
	end

	// Thirds of the calibrated span per axis.
	always_comb
	begin
		sx = {2'b00, live_q.xmax} - {2'b00, live_q.xmin};
		sy = {2'b00, live_q.ymax} - {2'b00, live_q.ymin};
		x_base = live_q.xmin;
		y_base = live_q.ymin;
	end

	// Thresholds are registered and lag a bound change by one cycle.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			x1_q <= '0;
			x2_q <= '0;
			y1_q <= '0;
			y2_q <= '0;
		end
		else
		begin
			x1_q <= x_base + (`TRCM_COORD_W)'(sx / 3);
			x2_q <= x_base + (`TRCM_COORD_W)'((sx * 2) / 3);
			y1_q <= y_base + (`TRCM_COORD_W)'(sy / 3);
			y2_q <= y_base + (`TRCM_COORD_W)'((sy * 2) / 3);
		end
	end

	always_comb
	begin
		col = (touch.x < x1_q) ? 2'd0 : ((touch.x < x2_q) ? 2'd1 : 2'd2);
		row = (touch.y < y1_q) ? 2'd0 : ((touch.y < y2_q) ? 2'd1 : 2'd2);
	end

	// Grid position to region number, clockwise from top-left, centre last.
	function automatic logic [3:0] region_of(input logic [1:0] r, input logic [1:0] c);
		logic [3:0] n;
		n = 4'h9;
		unique case ({r, c})
			4'b0000: n = 4'h1;
			4'b0001: n = 4'h2;
			4'b0010: n = 4'h3;
			4'b0110: n = 4'h4;
			4'b1010: n = 4'h5;
			4'b1001: n = 4'h6;
			4'b1000: n = 4'h7;
			4'b0100: n = 4'h8;
			default: n = 4'h9;
		endcase
		return n;
	endfunction

	// A touch is taken only when idle and never with a calibration point.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q <= TRCM_IDLE;
			region_q <= 4'h0;
		end
		else
		begin
			unique case (st_q)
				TRCM_IDLE:
				if (touch.valid && !calib_pt_valid)
				begin
					region_q <= region_of(row, col);
					st_q <= TRCM_LOOK;
				end
				TRCM_LOOK: st_q <= TRCM_SEND;
				TRCM_SEND: st_q <= TRCM_IDLE;
				default: st_q <= TRCM_IDLE;
			endcase
		end
	end

	always_comb
	begin
		if (region_q == 4'h0)
			mem_raddr = (`TRCM_ADDR_W)'(live_q.source * `TRCM_NUM_REGIONS);
		else
			mem_raddr = (`TRCM_ADDR_W)'(live_q.source * `TRCM_NUM_REGIONS + region_q - 1);
		mem_we = reg_wr && reg_addr >= A_CODE && reg_addr < A_CODEHI;
		// Code entries sit one per address from the table base, all 54 reachable.
		mem_waddr = reg_addr[`TRCM_ADDR_W-1:0];
	end

	trcm_code_mem u_mem (
		.clk   (clk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (reg_wdata[`TRCM_CODE_W-1:0]),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	always_ff @(posedge clk)
	begin
		if (rst)
			cmd <= '0;
		else if (st_q == TRCM_SEND)
			cmd <= '{valid: 1'b1, region: region_q, code: mem_rdata};
		else
			cmd.valid <= 1'b0;
	end

	// Learn mode is set by command and cleared by reset only.
	always_ff @(posedge clk)
	begin
		if (rst)
			learn_q <= 1'b0;
		else if (reg_wr && reg_addr == A_CMD && reg_wdata[2])
			learn_q <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			touch_status_or_ir_learn_line_out <= 1'b0;
			touch_status_or_ir_learn_line_oe  <= 1'b0;
			mute_or_ir_supply_line            <= 1'b0;
			panel_disconnect                  <= 1'b0;
			ir_learn_valid                    <= 1'b0;
		end
		else
		begin
			panel_disconnect <= live_q.intercept_mode &&
				(intercept_control_input == live_q.icept_hi);
			ir_learn_valid <= learn_q && touch_status_or_ir_learn_line_in;
			touch_status_or_ir_learn_line_oe <= !learn_q;
			touch_status_or_ir_learn_line_out <= panel_disconnect ?
				live_q.status_hi : !live_q.status_hi;
			if (learn_q)
				mute_or_ir_supply_line <= 1'b1;
			else
				mute_or_ir_supply_line <= navigation_unit_speaking ?
					live_q.mute_hi : !live_q.mute_hi;
		end
	end

	// Source switch: level while any source but the head unit is selected, or a pulse per change.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prev_src_q  <= `TRCM_HEAD_SRC;
			pulse_cnt_q <= '0;
		end
		else
		begin
			prev_src_q <= live_q.source;
			if (live_q.pulse_mode && prev_src_q != live_q.source)
				pulse_cnt_q <= 32'(PULSE_CYC);
			else if (pulse_cnt_q != 0)
				pulse_cnt_q <= pulse_cnt_q - 32'd1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			source_switch_output <= 1'b0;
			active_source        <= `TRCM_HEAD_SRC;
		end
		else
		begin
			active_source        <= live_q.source;
			source_switch_output <= live_q.pulse_mode ? (pulse_cnt_q != 0) :
				(live_q.source != `TRCM_HEAD_SRC);
		end
	end

	// Read data stand for one cycle after the strobe and are zero otherwise.
	always_ff @(posedge clk)
	begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				A_XMIN: reg_rdata <= 32'(live_q.xmin);
				A_XMAX: reg_rdata <= 32'(live_q.xmax);
				A_YMIN: reg_rdata <= 32'(live_q.ymin);
				A_YMAX: reg_rdata <= 32'(live_q.ymax);
				A_MODE: reg_rdata <= {27'h0, live_q.pulse_mode, live_q.intercept_mode,
					live_q.icept_hi, live_q.mute_hi, live_q.status_hi};
				A_SRC:  reg_rdata <= 32'(live_q.source);
				A_STAT: reg_rdata <= {24'h0, learn_q, panel_disconnect, 2'b00, region_q};
				default: reg_rdata <= 32'h0;
			endcase
		end
		else
			reg_rdata <= 32'h0;
	end
endmodule
`default_nettype wire

// ### tb/tb.sv
/*
 Self-checking bench of the mapper.
 Assumes the panel model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	import trcm_pkg::*;
	logic clk, rst, wr_s, rd_s, calv, cal2, press, icept, speak, ir_in, ir_out, oe;
	logic mute, disc, learn, sw;
	logic [7:0] adr;
	logic [31:0] wd, rdat;
	logic [11:0] px, py;
	logic [2:0] src;
	trcm_touch_t touch;
	trcm_cmd_t cmd;
	int miscompares, n_compared;
	logic [3:0] rt [9] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'h4, 4'h7, 4'h6, 4'h5};
	trcm_top #(.PULSE_CYC(20)) uut (.clk, .rst, .reg_addr(adr), .reg_wdata(wd),
		.reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .touch, .calib_pt_valid(calv),
		.calib_pt_second(cal2), .cmd, .intercept_control_input(icept),
		.navigation_unit_speaking(speak), .touch_status_or_ir_learn_line_in(ir_in),
		.touch_status_or_ir_learn_line_out(ir_out), .touch_status_or_ir_learn_line_oe(oe),
		.mute_or_ir_supply_line(mute), .panel_disconnect(disc), .ir_learn_valid(learn),
		.source_switch_output(sw), .active_source(src));
	trcm_panel_model u_panel (.clk, .rst, .press, .px, .py, .touch, .ir_out,
		.ir_oe(oe), .ir_in);
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		adr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(rdat, e);
	endtask
	task automatic wt;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic cal(input logic [11:0] x, input logic [11:0] y, input logic s);
		@(posedge clk);
		px <= x;
		py <= y;
		press <= 1'b1;
		@(posedge clk);
		press <= 1'b0;
		calv <= 1'b1;
		cal2 <= s;
		@(posedge clk);
		calv <= 1'b0;
		wt;
	endtask
	task automatic tap(input logic [11:0] x, input logic [11:0] y, input logic [3:0] r,
		input int idx);
		int n;
		n = 0;
		@(posedge clk);
		px <= x;
		py <= y;
		press <= 1'b1;
		@(posedge clk);
		press <= 1'b0;
		while (cmd.valid !== 1'b1 && n < 10)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(32'({cmd.valid, cmd.region, cmd.code}), 32'({1'b1, r, 16'ha000 + 16'(idx)}));
	endtask
	task automatic t_reset;
		rdc(8'h00, 32'h0);
		rdc(8'h04, 32'hfff);
		rdc(8'h30, 32'h0);
		chk1(oe, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_map;
		for (int i = 18; i < 54; i++)
			wr(8'h40 + 8'(i), 32'(16'ha000 + 16'(i)));
		cal(12'h100, 12'h100, 1'b0);
		cal(12'h400, 12'h700, 1'b1);
		rdc(8'h04, 32'h400);
		rdc(8'h0c, 32'h700);
		for (int s = 2; s < 6; s++)
		begin
			wr(8'h14, 32'(s));
			if (s > 2)
				tap(12'h280, 12'h400, 4'h9, s * 9 - 1);
			wr(8'h18, 32'h1);
			wt;
			chk(32'(src), 32'(s));
			chk1(sw, 1'b1);
			for (int c = 0; c < 9; c++)
				tap(12'h180 + 12'(c % 3) * 12'h100, 12'h200 + 12'(c / 3) * 12'h200,
					rt[c], s * 9 + int'(rt[c]) - 1);
		end
		$display("test map done");
	endtask
	task automatic t_side;
		int n;
		n = 0;
		wr(8'h10, 32'h1f);
		wr(8'h18, 32'h1);
		@(posedge clk) speak <= 1'b1;
		wt;
		chk1(mute, 1'b1);
		@(posedge clk) speak <= 1'b0;
		wt;
		chk1(mute, 1'b0);
		@(posedge clk) icept <= 1'b1;
		wt;
		chk1(disc, 1'b1);
		chk1(ir_in, 1'b1);
		@(posedge clk) icept <= 1'b0;
		wt;
		chk1(disc, 1'b0);
		chk1(ir_in, 1'b0);
		wr(8'h14, 32'h4);
		wr(8'h18, 32'h1);
		repeat (40)
		begin
			@(posedge clk);
			#1;
			n += int'(sw);
		end
		chk(32'(n), 32'd20);
		$display("test side done");
	endtask
	task automatic t_dflt;
		int n;
		n = 0;
		wr(8'h18, 32'h2);
		@(posedge clk) icept <= 1'b1;
		wt;
		chk1(disc, 1'b0);
		chk(32'(src), 32'h0);
		chk1(sw, 1'b0);
		wr(8'h18, 32'h4);
		wt;
		chk1(oe, 1'b0);
		chk1(mute, 1'b1);
		repeat (8)
		begin
			@(posedge clk);
			#1;
			n += int'(learn);
		end
		chk(32'(n), 32'd4);
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		wt;
		chk1(learn, 1'b0);
		chk1(oe, 1'b1);
		$display("test default done");
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clk);
		miscompares++;
		stop_test;
	end
	initial
	begin
		{rst, wr_s, rd_s, calv, cal2, press, icept, speak} = 8'h80;
		{adr, wd, px, py} = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_map;
		t_side;
		t_dflt;
		stop_test;
	end
endmodule
`default_nettype wire

// ### tb/trcm_panel_model.sv
/*
 Touch panel and IR receiver model.
 Assumes the bench asks for taps through press, px and py.
*/
`timescale 1ns/1ps
`default_nettype none
module trcm_panel_model (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Tap request
	input  wire logic             press,
	input  wire logic [11:0]      px,
	input  wire logic [11:0]      py,
	// Panel and learn line
	output trcm_pkg::trcm_touch_t touch,
	input  wire logic             ir_out,
	input  wire logic             ir_oe,
	output logic                  ir_in
);
	import trcm_pkg::*;
	logic rx_q;
	// Stale coordinates are inverted so they never look like a real tap.
	always_ff @(posedge clk)
	begin
		touch.valid <= press & ~rst;
		touch.x <= (press | rst) ? px : ~touch.x;
		touch.y <= (press | rst) ? py : ~touch.y;
		rx_q <= rst ? 1'b0 : ~rx_q;
	end
	assign ir_in = ir_oe ? ir_out : rx_q;
endmodule
`default_nettype wire

// ### tb/trcm_properties.sv
/*
 Concurrent checks on the mapper's ports.
 Assumes binding to trcm_top and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module trcm_checker (
	// Clock and reset
	input wire logic                   clk,
	input wire logic                   rst,
	// Ports watched
	input wire logic                   reg_wr,
	input wire trcm_pkg::trcm_touch_t  touch,
	input wire logic                   calib_pt_valid,
	input wire trcm_pkg::trcm_cmd_t    cmd,
	input wire logic                   intercept_control_input,
	input wire logic                   navigation_unit_speaking,
	input wire logic                   touch_status_or_ir_learn_line_oe,
	input wire logic                   mute_or_ir_supply_line,
	input wire logic                   panel_disconnect,
	input wire logic                   ir_learn_valid,
	input wire logic [2:0]             active_source
);
	import trcm_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_cmd_after_touch: assert property (
		cmd.valid |-> $past(touch.valid, 3)) else $error("code sent without a touch");
	a_cmd_one_pulse: assert property (
		cmd.valid |=> !cmd.valid) else $error("code pulse too long");
	a_region_range: assert property (
		cmd.valid |-> cmd.region inside {[4'h1:4'h9]}) else $error("region out of range");
	a_calib_blocks: assert property (
		cmd.valid |-> !$past(calib_pt_valid, 3)) else $error("code sent for a calibration touch");
	a_mute_follows: assert property (
		$rose(navigation_unit_speaking) && touch_status_or_ir_learn_line_oe
		|=> $changed(mute_or_ir_supply_line))
		else $error("mute line did not follow speech");
	a_learn_supply: assert property (
		ir_learn_valid |-> mute_or_ir_supply_line && !touch_status_or_ir_learn_line_oe)
		else $error("learn lines not switched");
	a_reset_clean: assert property (
		$past(rst) |-> !ir_learn_valid && !cmd.valid && active_source == 3'h0)
		else $error("outputs not clear after reset");
	a_disc_cause: assert property (
		$changed(panel_disconnect) |-> $past(intercept_control_input)
		!= $past(intercept_control_input, 2) || $past(reg_wr) || $past(reg_wr, 2))
		else $error("disconnect changed without cause");
	c_cmd: cover property (cmd.valid);
	c_learn: cover property ($rose(ir_learn_valid));
	c_disc: cover property ($rose(panel_disconnect));
endmodule
bind trcm_top trcm_checker u_chk (.clk, .rst, .reg_wr, .touch, .calib_pt_valid, .cmd,
	.intercept_control_input, .navigation_unit_speaking, .touch_status_or_ir_learn_line_oe,
	.mute_or_ir_supply_line, .panel_disconnect, .ir_learn_valid, .active_source);
`default_nettype wire
